// ===== logic/servo_stop_control.sv
// motion stop control: commanded stops, soft limits and drive enable
//
// What this block does
// - stop command halts, exits program, then holds
// - stop offers given, move, or maximum deceleration
// - broadcast id stop obeyed by every servo
// - halt ends every command, program and motion
// - halt frees drive and starts recovery
// - hard stop disables trajectory generator at once
// - immediate stop uses maximum deceleration
// - zero-velocity command ramps at its deceleration
// - profile exit ramps at register 23 deceleration
// - soft limits keep position strictly inside range, except when a halt, hard or immediate stop comes in the crossing cycle
// - limit crossing hard-stops one count inside limit, unless a halt, hard or immediate stop kills motion in that cycle
// - drive switch off removes torque, tracking continues
// - stop state codes false true falling rising
// - input stop captures trigger position
`timescale 1ns/1ps
module servo_stop_control
   import stop_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic [stop_pkg::ID_W-1:0]         servo_id,
   input  wire logic                              cmd_from_program,
   input  wire logic [stop_pkg::ID_W-1:0]         cmd_target_id,
   input  wire logic                              stop_exit_cmd,
   input  wire logic                              halt_disable_cmd,
   input  wire logic                              hard_stop_cmd,
   input  wire logic                              velocity_mode_protected_cmd,
   input  wire logic                              velocity_mode_immediate_cmd,
   input  wire logic                              profile_exit_cmd,
   input  wire logic                              soft_limit_cmd,
   input  wire stop_pkg::decel_sel_t              stop_decel_sel,
   input  wire logic [stop_pkg::ACC_W-1:0]        cmd_decel,
   input  wire logic signed [stop_pkg::VEL_W-1:0] cmd_velocity,
   input  wire logic [stop_pkg::ACC_W-1:0]        profile_decel_reg,
   input  wire logic signed [stop_pkg::POS_W-1:0] limit_lo_reg,
   input  wire logic signed [stop_pkg::POS_W-1:0] limit_hi_reg,
   input  wire logic                              move_start,
   input  wire logic                              move_is_profile,
   input  wire logic signed [stop_pkg::VEL_W-1:0] move_velocity,
   input  wire logic [stop_pkg::ACC_W-1:0]        move_accel,
   input  wire logic                              stop_enable,
   input  wire logic [1:0]                        stop_state,
   input  wire logic                              program_start,
   input  wire logic                              recovery_done,
   input  wire logic                              limit_status_clear,
   input  wire logic                              stop_input_pin,
   input  wire logic                              drive_enable_pin,
   output logic                                   drive_on,
   output logic                                   traj_enabled,
   output logic                                   program_running,
   output logic                                   holding,
   output logic                                   recovery_start,
   output logic                                   soft_limit_hit,
   output logic signed [stop_pkg::POS_W-1:0]      input_stop_pos,
   output logic signed [stop_pkg::POS_W-1:0]      position,
   output logic signed [stop_pkg::VEL_W-1:0]      velocity
);

   // ======================================================
   // state
   motion_state_t              state_q, state_d;
   logic signed [VEL_W-1:0]    target_q, target_d;
   logic [ACC_W-1:0]           rate_q, rate_d;
   logic [ACC_W-1:0]           move_accel_q;
   logic                       profile_q;
   logic                       limits_on_q;
   logic signed [POS_W-1:0]    lim_lo_q, lim_hi_q;
   logic [SYNC_DEPTH-1:0]      stop_sync_q, drv_sync_q;
   logic                       stop_lvl_q, stop_prev_q, drv_lvl_q;
   logic                       kill, pos_load;
   logic signed [POS_W-1:0]    pos_value;

   // ======================================================
   // pin synchronisers; level moves only once stages 2 and 3 agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_sync_q <= '0;
         drv_sync_q  <= '0;
      end else begin
         stop_sync_q <= {stop_sync_q[SYNC_DEPTH-2:0], stop_input_pin};
         drv_sync_q  <= {drv_sync_q[SYNC_DEPTH-2:0], drive_enable_pin};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_lvl_q  <= 1'b0;
         stop_prev_q <= 1'b0;
         drv_lvl_q   <= 1'b0;
      end else begin
         if (stop_sync_q[1] == stop_sync_q[2])
            stop_lvl_q <= stop_sync_q[2];
         stop_prev_q <= stop_lvl_q;
         if (drv_sync_q[1] == drv_sync_q[2])
            drv_lvl_q <= drv_sync_q[2];
      end
   end

   // ======================================================
   // command acceptance and priority
   function automatic logic stop_cond_met(
      input logic [1:0] code,
      input logic       lvl,
      input logic       prev);
      unique case (code)
         STOP_ON_FALSE:   stop_cond_met = !lvl;
         STOP_ON_TRUE:    stop_cond_met = lvl;
         STOP_ON_FALLING: stop_cond_met = prev && !lvl;
         STOP_ON_RISING:  stop_cond_met = !prev && lvl;
      endcase
   endfunction : stop_cond_met

   logic accepted, halt_go, hard_go, stop_go, vm_go, prof_go, in_stop_go;
   logic signed [POS_W-1:0] next_pos;
   logic lim_hi_trip, lim_lo_trip;

   always_comb begin
      accepted = cmd_from_program || cmd_target_id == servo_id
                 || cmd_target_id == BROADCAST_ID;
      halt_go  = accepted && halt_disable_cmd;
      hard_go  = accepted && hard_stop_cmd && !halt_go;
      stop_go  = accepted && stop_exit_cmd && !halt_go && !hard_go;
      vm_go    = accepted && (velocity_mode_protected_cmd || velocity_mode_immediate_cmd)
                 && !halt_go && !hard_go && !stop_go && state_q != ST_HALTED;
      prof_go  = accepted && profile_exit_cmd && profile_q && !vm_go
                 && !halt_go && !hard_go && !stop_go && state_q == ST_MOVE;
      in_stop_go = stop_enable && state_q == ST_MOVE
                   && stop_cond_met(stop_state, stop_lvl_q, stop_prev_q)
                   && !halt_go && !hard_go && !stop_go && !vm_go && !prof_go;
      next_pos    = position + POS_W'(velocity);
      lim_hi_trip = limits_on_q && next_pos >= lim_hi_q;
      lim_lo_trip = limits_on_q && next_pos <= lim_lo_q;
   end

   // ======================================================
   // motion state machine and ramp request
   always_comb begin
      state_d   = state_q;
      target_d  = target_q;
      rate_d    = rate_q;
      kill      = 1'b0;
      pos_load  = 1'b0;
      pos_value = position;
      if (halt_go) begin
         state_d  = ST_HALTED;
         target_d = VEL_RESET;
         kill     = 1'b1;
      end else if (hard_go) begin
         state_d  = (state_q == ST_HALTED) ? ST_HALTED : ST_IDLE;
         target_d = VEL_RESET;
         kill     = 1'b1;
      end else if (stop_go) begin
         target_d = VEL_RESET;
         unique case (stop_decel_sel)
            DECEL_GIVEN:      rate_d = cmd_decel;
            DECEL_MOVE_ACCEL: rate_d = move_accel_q;
            default:          kill   = 1'b1;
         endcase
         if (state_q != ST_HALTED)
            state_d = kill ? ST_HOLD : ST_STOPPING;
      end else if (vm_go) begin
         target_d = cmd_velocity;
         rate_d   = cmd_decel;
         state_d  = (cmd_velocity == VEL_RESET) ? ST_RAMP : ST_MOVE;
      end else if (prof_go) begin
         target_d = VEL_RESET;
         rate_d   = profile_decel_reg;
         state_d  = ST_RAMP;
      end else if (in_stop_go) begin
         target_d = VEL_RESET;
         rate_d   = move_accel_q;
         state_d  = ST_RAMP;
      end else if (move_start && state_q != ST_HALTED) begin
         target_d = move_velocity;
         rate_d   = move_accel;
         state_d  = ST_MOVE;
      end else begin
         unique case (state_q)
            ST_RAMP:     if (velocity == VEL_RESET) state_d = ST_IDLE;
            ST_STOPPING: if (velocity == VEL_RESET) state_d = ST_HOLD;
            ST_HALTED:   if (recovery_done) state_d = ST_IDLE;
            default:     state_d = state_q;
         endcase
      end
      // limit trip overrides the ramp only; the mode stays as it is
      if (!kill && lim_hi_trip) begin
         kill      = 1'b1;
         pos_load  = 1'b1;
         pos_value = lim_hi_q - POS_W'(1);
      end else if (!kill && lim_lo_trip) begin
         kill      = 1'b1;
         pos_load  = 1'b1;
         pos_value = lim_lo_q + POS_W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= ST_IDLE;
         target_q <= VEL_RESET;
         rate_q   <= RATE_RESET;
      end else begin
         state_q  <= state_d;
         target_q <= target_d;
         rate_q   <= rate_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         move_accel_q <= RATE_RESET;
         profile_q    <= 1'b0;
      end else if (halt_go || hard_go || stop_go || prof_go) begin
         profile_q    <= 1'b0;
      end else if (move_start && state_q != ST_HALTED) begin
         move_accel_q <= move_accel;
         profile_q    <= move_is_profile;
      end
   end

   // ======================================================
   // soft limits
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         limits_on_q <= 1'b0;
         lim_lo_q    <= POS_RESET;
         lim_hi_q    <= POS_RESET;
      end else if (soft_limit_cmd && accepted) begin
         limits_on_q <= 1'b1;
         lim_lo_q    <= limit_lo_reg;
         lim_hi_q    <= limit_hi_reg;
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         soft_limit_hit <= 1'b0;
      else if (lim_hi_trip || lim_lo_trip)
         soft_limit_hit <= 1'b1;
      else if (limit_status_clear)
         soft_limit_hit <= 1'b0;
   end

   // ======================================================
   // outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         input_stop_pos <= POS_RESET;
      else if (in_stop_go)
         input_stop_pos <= position;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         program_running <= 1'b0;
         recovery_start  <= 1'b0;
      end else begin
         recovery_start <= halt_go;
         if (halt_go || stop_go)
            program_running <= 1'b0;
         else if (program_start && state_q != ST_HALTED)
            program_running <= 1'b1;
      end
   end

   // drive switch off only removes torque; commands and tracking go on
   // flopped from next state so the outputs keep the same cycle as the state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_on     <= 1'b0;
         holding      <= 1'b0;
         traj_enabled <= 1'b0;
      end else begin
         drive_on     <= drv_lvl_q && state_d != ST_HALTED;
         holding      <= state_d == ST_HOLD;
         traj_enabled <= state_d == ST_MOVE || state_d == ST_RAMP
                         || state_d == ST_STOPPING;
      end
   end

   velocity_ramp u_ramp (
      .clk       (clk),
      .nrst      (nrst),
      .target    (target_q),
      .rate      (rate_q),
      .kill      (kill),
      .pos_load  (pos_load),
      .pos_value (pos_value),
      .vel_q     (velocity),
      .pos_q     (position)
   );

   // ======================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   function automatic logic kill_by_cmd();
      kill_by_cmd = halt_go || hard_go || (stop_go && stop_decel_sel == DECEL_MAX);
   endfunction : kill_by_cmd

   sequence halt_seen_s;
      halt_disable_cmd && accepted;
   endsequence

   sequence came_to_rest_s;
      state_q == ST_STOPPING && velocity == VEL_RESET && !halt_go && !hard_go
      && !stop_go && !vm_go && !move_start;
   endsequence

   halt_frees_drive_a: assert property (halt_seen_s |=> !drive_on && recovery_start)
      else $error("halt did not free drive");
   halt_ends_all_a: assert property (halt_seen_s |=> state_q == ST_HALTED
                                     && !program_running && velocity == VEL_RESET)
      else $error("halt left activity running");
   hard_kills_traj_a: assert property (hard_go |=> velocity == VEL_RESET && !traj_enabled)
      else $error("hard stop did not stop trajectory");
   stop_exits_a: assert property (stop_go |=> !program_running)
      else $error("stop left program running");
   stop_holds_a: assert property (came_to_rest_s |=> holding)
      else $error("stop did not settle into hold");
   max_decel_a: assert property (stop_go && stop_decel_sel == DECEL_MAX
                                 |=> velocity == VEL_RESET)
      else $error("immediate stop not immediate");
   given_decel_a: assert property (stop_go && stop_decel_sel == DECEL_GIVEN
                                   |=> rate_q == $past(cmd_decel))
      else $error("stop used wrong deceleration");
   broadcast_a: assert property (stop_exit_cmd && cmd_target_id == BROADCAST_ID
                                 && !halt_disable_cmd && !hard_stop_cmd
                                 |=> !program_running)
      else $error("broadcast stop ignored");
   vm_ramp_a: assert property (vm_go |=> rate_q == $past(cmd_decel)
                               && target_q == $past(cmd_velocity))
      else $error("velocity mode ramp wrong");
   prof_decel_a: assert property (prof_go |=> rate_q == $past(profile_decel_reg)
                                  && target_q == VEL_RESET)
      else $error("profile exit used wrong deceleration");
   limit_stop_a: assert property (lim_hi_trip && !kill_by_cmd() |=> velocity == VEL_RESET
                                  && position == $past(lim_hi_q) - POS_W'(1))
      else $error("limit stop not at limit");
   limit_flag_a: assert property ((lim_hi_trip || lim_lo_trip)
                                  |=> soft_limit_hit && state_q == $past(state_d))
      else $error("limit status not set");
   capture_pos_a: assert property (in_stop_go |=> input_stop_pos == $past(position))
      else $error("stop position not captured");
   drive_switch_a: assert property (!drv_lvl_q |=> !drive_on)
      else $error("torque on with switch off");
   priority_a: assert property (halt_seen_s ##0 hard_stop_cmd |=> state_q == ST_HALTED)
      else $error("halt lost priority");

endmodule : servo_stop_control

// ===== logic/stop_pkg.sv
// shared constants and types for the servo stop control block
package stop_pkg;

   // ======================================================
   // widths
   localparam int POS_W = 32;
   localparam int VEL_W = 16;
   localparam int ACC_W = 16;
   localparam int ID_W  = 8;

   // ======================================================
   // addressing
   localparam logic [ID_W-1:0] BROADCAST_ID = 8'hff;

   // ======================================================
   // stop-state encoding of a move's stop condition
   localparam logic [1:0] STOP_ON_FALSE   = 2'h0;
   localparam logic [1:0] STOP_ON_TRUE    = 2'h1;
   localparam logic [1:0] STOP_ON_FALLING = 2'h2;
   localparam logic [1:0] STOP_ON_RISING  = 2'h3;

   // ======================================================
   // data register numbers the block stands in for
   localparam int PROFILE_DECEL_REG_NUM = 23;
   localparam int STOP_POS_REG_NUM      = 4;

   // ======================================================
   // reset values and synchroniser depth
   localparam logic signed [POS_W-1:0] POS_RESET  = 32'sh0000_0000;
   localparam logic signed [VEL_W-1:0] VEL_RESET  = 16'sh0000;
   localparam logic [ACC_W-1:0]        RATE_RESET = 16'h0000;
   localparam int                      SYNC_DEPTH = 3;

   // ======================================================
   // deceleration choice carried by the stop-and-exit command
   typedef enum logic [1:0] {
      DECEL_GIVEN      = 2'h0,
      DECEL_MOVE_ACCEL = 2'h1,
      DECEL_MAX        = 2'h2
   } decel_sel_t;

   typedef enum {
      ST_IDLE,
      ST_MOVE,
      ST_RAMP,
      ST_STOPPING,
      ST_HOLD,
      ST_HALTED
   } motion_state_t;

endpackage : stop_pkg

// ===== logic/velocity_ramp.sv
// velocity ramp and position integrator used by the stop control
`timescale 1ns/1ps
module velocity_ramp
   import stop_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic signed [stop_pkg::VEL_W-1:0] target,
   input  wire logic [stop_pkg::ACC_W-1:0]        rate,
   input  wire logic                              kill,
   input  wire logic                              pos_load,
   input  wire logic signed [stop_pkg::POS_W-1:0] pos_value,
   output logic signed [stop_pkg::VEL_W-1:0]      vel_q,
   output logic signed [stop_pkg::POS_W-1:0]      pos_q
);

   // ======================================================
   // step toward target, limited by rate in both directions
   function automatic logic signed [VEL_W:0] ramp_step(
      input logic signed [VEL_W-1:0] tgt,
      input logic signed [VEL_W-1:0] cur,
      input logic [ACC_W-1:0]        lim);
      logic signed [VEL_W:0] diff;
      logic signed [VEL_W:0] slim;
      // sign-extend both before subtracting; an unsigned term would zero-extend them
      diff = (VEL_W+1)'(tgt) - (VEL_W+1)'(cur);
      slim = {1'b0, lim};
      if (diff > slim)
         ramp_step = slim;
      else if (diff < -slim)
         ramp_step = -slim;
      else
         ramp_step = diff;
   endfunction : ramp_step

   logic signed [VEL_W:0] vel_next;

   always_comb begin
      vel_next = (VEL_W+1)'(vel_q) + ramp_step(target, vel_q, rate);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         vel_q <= VEL_RESET;
      else if (kill)
         vel_q <= VEL_RESET;
      else
         vel_q <= vel_next[VEL_W-1:0];
   end

   // position keeps counting whatever the drive does
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pos_q <= POS_RESET;
      else if (pos_load)
         pos_q <= pos_value;
      else
         pos_q <= pos_q + POS_W'(vel_q);
   end

endmodule : velocity_ramp

// ===== tb/host_cmd_model.sv
// host side model that sends one-cycle motion command pulses
`timescale 1ns/1ps
module host_cmd_model
   import stop_pkg::*;
#(
   parameter int MAX_DECEL = 16'h00ff
)(
   input  wire logic                  clk,
   output logic [6:0]                 cmd_q,
   output logic [stop_pkg::ACC_W-1:0] decel_q
);
   // ==========================================================
   // command issue
   initial begin
      cmd_q   = 7'h00;
      decel_q = 16'h0001;
   end

   // bits: stop, halt, hard stop, vel protected, vel immediate, profile exit, soft limit
   // decel stands after the pulse, as a real host leaves its argument in place
   task automatic issue(input logic [6:0] m, input logic [ACC_W-1:0] d);
      @(negedge clk);
      cmd_q   = m;
      decel_q = (d > MAX_DECEL) ? MAX_DECEL[ACC_W-1:0] : d;
      @(negedge clk);
      cmd_q = 7'h00;
   endtask : issue
endmodule : host_cmd_model

// ===== tb/tb_servo_stop_control.sv
// self-checking bench for the servo stop control block
`timescale 1ns/1ps
module tb_servo_stop_control;
   import stop_pkg::*;
   logic                    clk, nrst, cmd_from_program, move_start, move_is_profile;
   logic                    stop_enable, program_start, recovery_done, limit_status_clear;
   logic                    stop_input_pin, drive_enable_pin, drive_on, traj_enabled;
   logic                    program_running, holding, recovery_start, soft_limit_hit;
   logic [ID_W-1:0]         servo_id, cmd_target_id;
   decel_sel_t              stop_decel_sel;
   logic [ACC_W-1:0]        cmd_decel, profile_decel_reg, move_accel;
   logic signed [VEL_W-1:0] cmd_velocity, move_velocity, velocity;
   logic signed [POS_W-1:0] limit_lo_reg, limit_hi_reg, input_stop_pos, position, p0;
   logic [1:0]              stop_state;
   logic [6:0]              cmd;
   int                      n_fail, n_tests, v, a, d;

   host_cmd_model host (.clk, .cmd_q(cmd), .decel_q(cmd_decel));
   servo_stop_control DUT (.clk, .nrst, .servo_id, .cmd_from_program, .cmd_target_id,
      .stop_exit_cmd(cmd[0]), .halt_disable_cmd(cmd[1]), .hard_stop_cmd(cmd[2]),
      .velocity_mode_protected_cmd(cmd[3]), .velocity_mode_immediate_cmd(cmd[4]),
      .profile_exit_cmd(cmd[5]), .soft_limit_cmd(cmd[6]), .stop_decel_sel, .cmd_decel,
      .cmd_velocity, .profile_decel_reg, .limit_lo_reg, .limit_hi_reg, .move_start,
      .move_is_profile, .move_velocity, .move_accel, .stop_enable, .stop_state,
      .program_start, .recovery_done, .limit_status_clear, .stop_input_pin,
      .drive_enable_pin, .drive_on, .traj_enabled, .program_running, .holding,
      .recovery_start, .soft_limit_hit, .input_stop_pos, .position, .velocity);

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // random speed and rate, started together with a program
   task automatic move(input logic prof);
      v = 20 + $urandom % 80;
      a = 1 + $urandom % 8;
      @(negedge clk);
      move_velocity = v[15:0];
      move_accel = a[15:0];
      move_is_profile = prof;
      move_start = 1'b1;
      program_start = 1'b1;
      @(negedge clk);
      move_start = 1'b0;
      program_start = 1'b0;
      for (int i = 0; i < 200 && velocity !== v[15:0]; i++) @(negedge clk);
   endtask : move

   // cycles to rest must match speed over rate, give or take the launch edge
   task automatic ramp(input int r);
      int n;
      n = 0;
      while (velocity !== 16'sh0000 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check(n >= v / r - 1 && n <= v / r + 2, 1'b1);
   endtask : ramp

   task automatic recover();
      @(negedge clk);
      recovery_done = 1'b1;
      @(negedge clk);
      recovery_done = 1'b0;
      @(negedge clk);
   endtask : recover

   // ==========================================================
   // clock, watchdog and tests
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // tests need a few thousand cycles; this allows about 25000
   initial begin
      #1_000_000;
      n_fail++;
      give_verdict();
   end

   initial begin
      {nrst, cmd_from_program, move_start, move_is_profile, stop_enable} = 5'h00;
      {program_start, recovery_done, limit_status_clear, stop_input_pin} = 4'h0;
      {stop_state, cmd_velocity, move_velocity, move_accel} = 50'h0;
      drive_enable_pin = 1'b1;
      servo_id = 8'h05;
      cmd_target_id = 8'h05;
      stop_decel_sel = DECEL_MAX;
      profile_decel_reg = 16'h0003;
      limit_lo_reg = -32'sh0010_0000;
      limit_hi_reg = 32'sh0010_0000;
      void'($urandom(65));
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (6) @(negedge clk);
      check(drive_on, 1'b1);
      for (int s = 0; s < 3; s++) begin
         move(1'b0);
         d = 1 + $urandom % 8;
         stop_decel_sel = decel_sel_t'(s);
         host.issue(7'h01, s == 0 ? d[15:0] : 16'h0040);
         check(program_running, 1'b0);
         ramp(s == 0 ? d : s == 1 ? a : 32'h7fff);
         @(negedge clk);
         check(holding, 1'b1);
      end
      $display("stop decel choices done");
      move(1'b0);
      cmd_target_id = 8'h77;
      host.issue(7'h01, 16'h0001);
      check(velocity, v);
      cmd_target_id = BROADCAST_ID;
      host.issue(7'h01, 16'h0001);
      check(velocity, 0);
      cmd_target_id = servo_id;
      $display("broadcast done");
      move(1'b0);
      host.issue(7'h02, 16'h0001);
      check({drive_on, recovery_start, program_running}, 3'h2);
      check(velocity, 0);
      @(negedge clk);
      check(recovery_start, 1'b0);
      recover();
      check(drive_on, 1'b1);
      $display("halt done");
      move(1'b0);
      host.issue(7'h04, 16'h0001);
      check({velocity, traj_enabled, program_running}, 18'h00001);
      $display("hard stop done");
      for (int m = 3; m < 5; m++) begin
         move(1'b0);
         d = 1 + $urandom % 8;
         cmd_velocity = 16'sh0000;
         host.issue(7'h01 << m, d[15:0]);
         ramp(d);
      end
      profile_decel_reg = 16'(1 + $urandom % 8);
      move(1'b0);
      host.issue(7'h20, 16'h0001);
      check(velocity, v);
      host.issue(7'h04, 16'h0001);
      move(1'b1);
      host.issue(7'h20, 16'h0040);
      ramp(profile_decel_reg);
      $display("ramped stops done");
      for (int c = 0; c < 4; c++) begin
         stop_enable = 1'b0;
         stop_state = c[1:0];
         stop_input_pin = ~c[0];
         repeat (6) @(negedge clk);
         stop_enable = 1'b1;
         move(1'b0);
         p0 = position;
         stop_input_pin = c[0];
         for (int i = 0; i < 10 && velocity === v[15:0]; i++) @(negedge clk);
         ramp(a);
         check(input_stop_pos >= p0 && input_stop_pos <= p0 + 8 * v, 1'b1);
      end
      stop_enable = 1'b0;
      $display("input stop done");
      drive_enable_pin = 1'b0;
      move(1'b0);
      repeat (6) @(negedge clk);
      check(drive_on, 1'b0);
      p0 = position;
      @(negedge clk);
      check(position, p0 + v);
      drive_enable_pin = 1'b1;
      host.issue(7'h04, 16'h0001);
      move(1'b0);
      host.issue(7'h07, 16'h0001);
      check({recovery_start, drive_on}, 2'h2);
      recover();
      $display("drive pin and priority done");
      limit_lo_reg = position - 32'sh0000_0100;
      limit_hi_reg = position + 32'sh0000_0100;
      host.issue(7'h40, 16'h0001);
      move(1'b0);
      repeat (30) @(negedge clk);
      check(position, limit_hi_reg - 1);
      check({soft_limit_hit, traj_enabled}, 2'h3);
      $display("soft limit done");
      give_verdict();
   end
endmodule : tb_servo_stop_control
